// [hdl/asrm_pkg.sv]
// Package: shared constants and types for the async RAM host controller
package asrm_pkg;
    // ----------------------------------------
    // Geometry limits
    // ----------------------------------------
    localparam int unsigned ASRM_DEPTH_STEP = 16;   // Depth granularity in words
    localparam int unsigned ASRM_DEPTH_MAX  = 256;  // Deepest single macro
    localparam int unsigned ASRM_WIDTH_MAX  = 32;   // Widest single macro
    localparam int unsigned ASRM_BITS_MAX   = 8192; // Capacity ceiling per macro
    // Chosen macro shape, fixed
    localparam int unsigned ASRM_DEPTH      = 256;
    localparam int unsigned ASRM_WIDTH      = 32;
    localparam int unsigned ASRM_AW         = 8;
    // ----------------------------------------
    // Strobe timing, in ns and in cycles
    // ----------------------------------------
    localparam int unsigned ASRM_CLK_NS     = 20;
    localparam int unsigned ASRM_SETUP_NS   = 20;   // Address settle before strobe
    localparam int unsigned ASRM_PULSE_NS   = 20;   // Write strobe width
    localparam int unsigned ASRM_HOLD_NS    = 20;   // Address hold after strobe
    localparam int unsigned ASRM_READ_NS    = 40;   // Read access wait
    localparam logic [3:0]  ASRM_SETUP_CYC  = 4'((ASRM_SETUP_NS + ASRM_CLK_NS - 1) / ASRM_CLK_NS);
    localparam logic [3:0]  ASRM_PULSE_CYC  = 4'((ASRM_PULSE_NS + ASRM_CLK_NS - 1) / ASRM_CLK_NS);
    localparam logic [3:0]  ASRM_HOLD_CYC   = 4'((ASRM_HOLD_NS + ASRM_CLK_NS - 1) / ASRM_CLK_NS);
    localparam logic [3:0]  ASRM_READ_CYC   = 4'((ASRM_READ_NS + ASRM_CLK_NS - 1) / ASRM_CLK_NS);
    // ----------------------------------------
    // Sequencer states and write methods
    // ----------------------------------------
    typedef enum logic [2:0] {
        ASRM_IDLE  = 3'b000,
        ASRM_SETUP = 3'b001,
        ASRM_PULSE = 3'b010,
        ASRM_HOLD  = 3'b011,
        ASRM_READ  = 3'b100
    } asrm_state_e;
    typedef enum logic {
        ASRM_WM_SEL = 1'b0,   // Hold select, pulse the write strobe
        ASRM_WM_ARR = 1'b1    // Hold write level, pulse array select
    } asrm_wmode_e;
endpackage : asrm_pkg

// [hdl/asrm_seq_if.sv]
// Interface: request channel between host top and its strobe timer
`timescale 1ns/1ns
interface asrm_seq_if;
    logic       start;   // Load the timer
    logic [3:0] count;   // Cycles to wait
    logic       done;    // Timer expired, one-cycle pulse
    modport ctl (output start, output count, input done);
    modport tmr (input start, input count, output done);
endinterface : asrm_seq_if

// [hdl/asrm_timer.sv]
// Module: down-counter that paces each strobe phase
`timescale 1ns/1ns
module asrm_timer
    import asrm_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    asrm_seq_if.tmr     seq
);
    logic [3:0] cnt_r;
    logic       run_r;

    // ----------------------------------------
    // Phase counter
    // ----------------------------------------
    // Count down from the loaded figure; done fires on the last cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            run_r <= 1'b0;
        end else if (seq.start) begin
            cnt_r <= seq.count;
            run_r <= 1'b1;
        end else if (run_r) begin
            cnt_r <= cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
                run_r <= 1'b0;
            end
        end
    end

    assign seq.done = run_r && (cnt_r == 4'h1);
endmodule : asrm_timer

// [hdl/asrm_host.sv]
// Module: host sequencer driving one async single- or dual-port RAM macro
`timescale 1ns/1ns
module asrm_host
    import asrm_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // User request side
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire logic                  req_write,
    input  wire asrm_wmode_e           req_wmode,
    input  wire logic [ASRM_AW-1:0]    req_addr,
    input  wire logic [ASRM_WIDTH-1:0] req_wdata,
    output logic                       rsp_valid,
    output logic [ASRM_WIDTH-1:0]      rsp_rdata,
    // Single-port macro pins
    output logic                       sp_array_sel,
    output logic                       sp_read_sel,
    output logic [ASRM_AW-1:0]         shared_addr,
    // Dual-port macro pins
    output logic                       dp_array_sel,
    output logic                       dp_read_en,
    output logic                       dp_write_en,
    output logic [ASRM_AW-1:0]         read_addr,
    output logic [ASRM_AW-1:0]         write_addr,
    // Shared data pins; each macro gets its own read bus
    output logic [ASRM_WIDTH-1:0]      write_data_in,
    input  wire logic [ASRM_WIDTH-1:0] sp_read_data_out,
    input  wire logic [ASRM_WIDTH-1:0] dp_read_data_out,
    input  wire logic                  use_dual
);
    // ----------------------------------------
    // Static shape checks
    // ----------------------------------------
    // Shape is fixed, so these only guard edits of the package
    initial begin
        if ((ASRM_DEPTH % ASRM_DEPTH_STEP) != 0 || ASRM_DEPTH > ASRM_DEPTH_MAX) begin
            $error("Bad macro depth");
        end
        if (ASRM_WIDTH > ASRM_WIDTH_MAX || ASRM_WIDTH < 1) begin
            $error("Bad macro width");
        end
        if (ASRM_DEPTH * ASRM_WIDTH > ASRM_BITS_MAX) begin
            $error("Macro exceeds capacity");
        end
    end

    asrm_state_e                state_r;
    logic                       wr_r;
    asrm_wmode_e                wm_r;
    logic                       dual_r;
    logic [ASRM_AW-1:0]         addr_r;
    logic [ASRM_WIDTH-1:0]      wdata_r;
    logic                       dual_m1_r;
    logic                       dual_m2_r;
    asrm_seq_if                 seq ();

    // ----------------------------------------
    // Phase timer
    // ----------------------------------------
    asrm_timer u_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .seq   (seq)
    );

    // Variant strap is external; two flops before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dual_m1_r <= 1'b0;
            dual_m2_r <= 1'b0;
        end else begin
            dual_m1_r <= use_dual;
            dual_m2_r <= dual_m1_r;
        end
    end

    assign req_ready = (state_r == ASRM_IDLE);

    // Load the timer whenever a phase begins
    always_comb begin
        seq.start = 1'b0;
        seq.count = ASRM_SETUP_CYC;
        unique case (state_r)
            ASRM_IDLE: begin
                seq.start = req_valid;
                // Pins lag state by a cycle, so one extra keeps the full access wait
                seq.count = req_write ? ASRM_SETUP_CYC : 4'(ASRM_READ_CYC + 4'h1);
            end
            ASRM_SETUP: begin
                seq.start = seq.done;
                seq.count = ASRM_PULSE_CYC;
            end
            ASRM_PULSE: begin
                seq.start = seq.done;
                seq.count = ASRM_HOLD_CYC;
            end
            ASRM_HOLD, ASRM_READ: begin
                seq.start = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    // Address stays fixed across setup, pulse and hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ASRM_IDLE;
            wr_r    <= 1'b0;
            wm_r    <= ASRM_WM_SEL;
            dual_r  <= 1'b0;
            addr_r  <= '0;
            wdata_r <= '0;
        end else begin
            unique case (state_r)
                ASRM_IDLE: begin
                    if (req_valid) begin
                        wr_r    <= req_write;
                        wm_r    <= req_wmode;
                        dual_r  <= dual_m2_r;
                        addr_r  <= req_addr;
                        wdata_r <= req_wdata;
                        state_r <= req_write ? ASRM_SETUP : ASRM_READ;
                    end
                end
                ASRM_SETUP: if (seq.done) state_r <= ASRM_PULSE;
                ASRM_PULSE: if (seq.done) state_r <= ASRM_HOLD;
                ASRM_HOLD:  if (seq.done) state_r <= ASRM_IDLE;
                ASRM_READ:  if (seq.done) state_r <= ASRM_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Single-port pin drive
    // ----------------------------------------
    // Write by select pulse or by array-select pulse; fall of pulse latches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_array_sel <= 1'b0;
            sp_read_sel  <= 1'b1;
            shared_addr  <= '0;
        end else begin
            shared_addr <= addr_r;
            if (dual_r || state_r == ASRM_IDLE) begin
                sp_array_sel <= 1'b0;
                sp_read_sel  <= 1'b1;
            end else if (state_r == ASRM_READ) begin
                sp_array_sel <= 1'b1;
                sp_read_sel  <= 1'b1;
            end else if (wm_r == ASRM_WM_SEL) begin
                sp_array_sel <= 1'b1;
                sp_read_sel  <= (state_r != ASRM_PULSE);
            end else begin
                sp_array_sel <= (state_r == ASRM_PULSE);
                sp_read_sel  <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Dual-port pin drive
    // ----------------------------------------
    // Idle keeps both enables low: standby
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_array_sel <= 1'b0;
            dp_read_en   <= 1'b0;
            dp_write_en  <= 1'b0;
            read_addr    <= '0;
            write_addr   <= '0;
        end else begin
            read_addr  <= addr_r;
            write_addr <= addr_r;
            if (!dual_r || state_r == ASRM_IDLE) begin
                dp_array_sel <= 1'b0;
                dp_read_en   <= 1'b0;
                dp_write_en  <= 1'b0;
            end else if (state_r == ASRM_READ) begin
                dp_array_sel <= 1'b1;
                dp_read_en   <= 1'b1;
                dp_write_en  <= 1'b0;
            end else if (wm_r == ASRM_WM_SEL) begin
                // One access at a time, so never same-address overlap
                dp_array_sel <= 1'b1;
                dp_read_en   <= 1'b0;
                dp_write_en  <= (state_r == ASRM_PULSE);
            end else begin
                dp_array_sel <= (state_r == ASRM_PULSE);
                dp_read_en   <= 1'b0;
                dp_write_en  <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Data paths
    // ----------------------------------------
    // Sample read data on the last wait cycle, when access time has passed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_data_in <= '0;
            rsp_valid     <= 1'b0;
            rsp_rdata     <= '0;
        end else begin
            write_data_in <= wdata_r;
            rsp_valid     <= (state_r == ASRM_READ) && seq.done;
            if (state_r == ASRM_READ && seq.done) begin
                rsp_rdata <= dual_r ? dp_read_data_out : sp_read_data_out;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_wr_pulse;
        (state_r == ASRM_PULSE && seq.done) ##1 (state_r == ASRM_HOLD);
    endsequence
    property p_pulse_then_hold;
        @(posedge clk) disable iff (!rst_n)
        s_wr_pulse |-> ##1 (sp_read_sel || !sp_array_sel) && !(dp_array_sel && dp_write_en);
    endproperty
    a_pulse_then_hold: assert property (p_pulse_then_hold)
        else $error("Write strobe not released after pulse");
    property p_sp_idle_standby;
        @(posedge clk) disable iff (!rst_n)
        (state_r == ASRM_IDLE) |=> !sp_array_sel && !dp_array_sel;
    endproperty
    a_sp_idle_standby: assert property (p_sp_idle_standby)
        else $error("Array select high while idle");
    property p_read_sel_high;
        @(posedge clk) disable iff (!rst_n)
        (state_r == ASRM_READ && !dual_r) |=> sp_read_sel && sp_array_sel;
    endproperty
    a_read_sel_high: assert property (p_read_sel_high)
        else $error("Read without select high");
    property p_dp_no_write_on_read;
        @(posedge clk) disable iff (!rst_n)
        dp_read_en |-> !dp_write_en;
    endproperty
    a_dp_no_write_on_read: assert property (p_dp_no_write_on_read)
        else $error("Read and write overlap");
    property p_addr_stable;
        @(posedge clk) disable iff (!rst_n)
        (state_r == ASRM_PULSE) |=> $stable(shared_addr) && $stable(write_addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("Address moved during write");
    property p_rsp_follows_read;
        @(posedge clk) disable iff (!rst_n)
        rsp_valid |-> $past(state_r) == ASRM_READ;
    endproperty
    a_rsp_follows_read: assert property (p_rsp_follows_read)
        else $error("Response without read");
    property p_dp_read_en;
        @(posedge clk) disable iff (!rst_n)
        (state_r == ASRM_READ && dual_r) |=> dp_read_en && dp_array_sel;
    endproperty
    a_dp_read_en: assert property (p_dp_read_en)
        else $error("Dual-port read enables low");
    property p_dp_arr_pulse;
        @(posedge clk) disable iff (!rst_n)
        (dual_r && wm_r == ASRM_WM_ARR && state_r == ASRM_SETUP) |=> dp_write_en && !dp_array_sel;
    endproperty
    a_dp_arr_pulse: assert property (p_dp_arr_pulse)
        else $error("Array-select write setup wrong");
endmodule : asrm_host

// [verification/asrm_ram_model.sv]
// Model: behavioural asynchronous single-port and dual-port RAM macros
`timescale 1ns/1ns
module asrm_ram_model
    import asrm_pkg::*;
(
    input  wire logic                  sp_array_sel,
    input  wire logic                  sp_read_sel,
    input  wire logic [ASRM_AW-1:0]    shared_addr,
    input  wire logic                  dp_array_sel,
    input  wire logic                  dp_read_en,
    input  wire logic                  dp_write_en,
    input  wire logic [ASRM_AW-1:0]    read_addr,
    input  wire logic [ASRM_AW-1:0]    write_addr,
    input  wire logic [ASRM_WIDTH-1:0] write_data_in,
    output logic [ASRM_WIDTH-1:0]      sp_read_data_out,
    output logic [ASRM_WIDTH-1:0]      dp_read_data_out
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // One array per macro, 256 x 32 fills the capacity ceiling exactly
    logic [ASRM_WIDTH-1:0] sp_mem [ASRM_DEPTH];
    logic [ASRM_WIDTH-1:0] dp_mem [ASRM_DEPTH];
    logic [ASRM_WIDTH-1:0] junk_r = 32'h5a5a_a5a5;
    logic                  sp_wr;
    logic                  dp_wr;
    logic                  dp_rd_ok;
    // Undefined output toggles, so a stale value can never pass for read data
    always #7 junk_r = ~junk_r;
    // ----------------------------------------
    // Write strobes, data latched at the fall
    // ----------------------------------------
    assign sp_wr = sp_array_sel & ~sp_read_sel;
    always @(negedge sp_wr) sp_mem[shared_addr] <= write_data_in;
    assign dp_wr = dp_array_sel & dp_write_en;
    always @(negedge dp_wr) dp_mem[write_addr] <= write_data_in;
    // Read paths; standby and same-word collisions give no usable data
    assign sp_read_data_out = (sp_array_sel & sp_read_sel) ? sp_mem[shared_addr] : junk_r;
    assign dp_rd_ok = dp_array_sel & dp_read_en & ~(dp_wr & (read_addr == write_addr));
    assign dp_read_data_out = dp_rd_ok ? dp_mem[read_addr] : junk_r;
endmodule : asrm_ram_model

// [verification/asrm_host_tb.sv]
// Testbench: host sequencer driving the behavioural RAM macro model
`timescale 1ns/1ns
module asrm_host_tb
    import asrm_pkg::*;
;
    logic                  clk, rst_n, req_valid, req_ready, req_write, rsp_valid, use_dual;
    logic                  sp_array_sel, sp_read_sel, dp_array_sel, dp_read_en, dp_write_en;
    asrm_wmode_e           req_wmode;
    logic [ASRM_AW-1:0]    req_addr, shared_addr, read_addr, write_addr;
    logic [ASRM_WIDTH-1:0] req_wdata, rsp_rdata, write_data_in, sp_rdo, dp_rdo;
    int                    n_errors = 0;
    int                    check_count = 0;
    int                    cyc = 0;

    asrm_host i_asrm_host (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_wmode(req_wmode),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .sp_array_sel(sp_array_sel), .sp_read_sel(sp_read_sel),
        .shared_addr(shared_addr), .dp_array_sel(dp_array_sel), .dp_read_en(dp_read_en),
        .dp_write_en(dp_write_en), .read_addr(read_addr), .write_addr(write_addr),
        .write_data_in(write_data_in), .sp_read_data_out(sp_rdo),
        .dp_read_data_out(dp_rdo), .use_dual(use_dual));
    asrm_ram_model i_asrm_ram_model (.sp_array_sel(sp_array_sel), .sp_read_sel(sp_read_sel),
        .shared_addr(shared_addr), .dp_array_sel(dp_array_sel), .dp_read_en(dp_read_en),
        .dp_write_en(dp_write_en), .read_addr(read_addr), .write_addr(write_addr),
        .write_data_in(write_data_in), .sp_read_data_out(sp_rdo), .dp_read_data_out(dp_rdo));

    // ----------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Whole run needs under a hundred cycles; a hang is cut short well past that
    always @(posedge clk) begin
        cyc++;
        if (cyc >= 2000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic check(input string what, input logic [ASRM_WIDTH-1:0] seen,
                         input logic [ASRM_WIDTH-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Inputs always move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic issue(input logic wr, input asrm_wmode_e m, input logic [ASRM_AW-1:0] a,
                         input logic [ASRM_WIDTH-1:0] d);
        int i;
        for (i = 0; i < 10 && req_ready !== 1'b1; i++) step(1);
        check("ready", 32'(req_ready), 32'h1);
        req_valid = 1'b1;
        req_write = wr;
        req_wmode = m;
        req_addr = a;
        req_wdata = d;
        step(1);
        req_valid = 1'b0;
    endtask : issue
    task automatic do_write(input logic dual, input asrm_wmode_e m, input logic [ASRM_AW-1:0] a,
                            input logic [ASRM_WIDTH-1:0] d);
        logic [5:0] exp;
        logic [1:0] pins;
        int         k;
        // Strobe pair for cycles 1..3 after take, array select first
        case ({dual, m})
            2'b00: exp = 6'b11_10_11;
            2'b01: exp = 6'b00_10_00;
            2'b10: exp = 6'b10_11_10;
            default: exp = 6'b01_11_01;
        endcase
        issue(1'b1, m, a, d);
        for (k = 2; k >= 0; k--) begin
            step(1);
            pins = dual ? {dp_array_sel, dp_write_en} : {sp_array_sel, sp_read_sel};
            check("write strobes", 32'(pins), 32'(exp[2*k +: 2]));
        end
        check("write addr", 32'(dual ? write_addr : shared_addr), 32'(a));
        check("write data", write_data_in, d);
    endtask : do_write
    task automatic do_read(input logic dual, input logic [ASRM_AW-1:0] a,
                           input logic [ASRM_WIDTH-1:0] exp);
        logic [2:0] pins;
        int         k;
        issue(1'b0, ASRM_WM_SEL, a, 32'h0);
        step(1);
        pins = dual ? {dp_array_sel, dp_read_en, dp_write_en} : {sp_array_sel, sp_read_sel, 1'b0};
        check("read strobes", 32'(pins), 32'h6);
        check("read addr", 32'(dual ? read_addr : shared_addr), 32'(a));
        for (k = 1; k < 10 && rsp_valid !== 1'b1; k++) step(1);
        check("read latency", 32'(k), 32'h3);
        check("read data", rsp_rdata, exp);
    endtask : do_read
    // The variant select passes two flops before the sequencer sees it
    task automatic set_dual(input logic v);
        use_dual = v;
        step(3);
    endtask : set_dual

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_sp();
        do_write(1'b0, ASRM_WM_SEL, 8'h00, 32'h0000_0001);
        do_write(1'b0, ASRM_WM_ARR, 8'hff, 32'h8000_0000);
        step(5);
        do_read(1'b0, 8'h00, 32'h0000_0001);
        do_read(1'b0, 8'hff, 32'h8000_0000);
        $display("test_sp done");
    endtask : test_sp
    task automatic test_dp();
        set_dual(1'b1);
        do_write(1'b1, ASRM_WM_SEL, 8'h00, 32'hdead_beef);
        do_write(1'b1, ASRM_WM_ARR, 8'h80, 32'h1234_5678);
        do_read(1'b1, 8'h80, 32'h1234_5678);
        do_read(1'b1, 8'h00, 32'hdead_beef);
        set_dual(1'b0);
        // Dual-port traffic must leave the single-port word alone
        do_read(1'b0, 8'h00, 32'h0000_0001);
        $display("test_dp done");
    endtask : test_dp
    task automatic test_refuse();
        issue(1'b1, ASRM_WM_SEL, 8'h42, 32'h0f0f_0f0f);
        check("busy", 32'(req_ready), 32'h0);
        // A request while busy is dropped, not queued
        step(1);
        req_valid = 1'b1;
        req_addr = 8'h42;
        req_wdata = 32'hf0f0_f0f0;
        step(1);
        req_valid = 1'b0;
        do_read(1'b0, 8'h42, 32'h0f0f_0f0f);
        $display("test_refuse done");
    endtask : test_refuse
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_wmode = ASRM_WM_SEL;
        req_addr = 8'h00;
        req_wdata = 32'h0;
        use_dual = 1'b0;
        step(3);
        check("reset pins", 32'({sp_array_sel, sp_read_sel, dp_array_sel, dp_read_en,
                                 dp_write_en, req_ready}), 32'h11);
        rst_n = 1'b1;
        step(3);
        test_sp();
        test_dp();
        test_refuse();
        wrap_up();
    end
endmodule : asrm_host_tb
